// >>> core/dss_pkg.sv
// Purpose: constants and types of the sequencer status block
// Assumes: 100 MHz clk, 12-bit register byte address
// Notes:   all offsets are byte addresses
// How it works
// RULE1 - buffer-drained bit 20 sets once last DMA value fetched
// RULE2 - buffer-drained clears on length write while DMA idle
// RULE3 - DMA error bit 18 sets on master or target abort
// RULE4 - DMA error stops the engine until disabled
// RULE5 - DMA error clears when DMA engine is disabled
// RULE6 - DMA busy bit 17 shows while engine transfers
// RULE7 - DMA idle bit 16 shows while engine rests idle
// RULE8 - length write while idle validates buffer and starts fetching
// RULE9 - frame mode: trigger before count done sets frame error bit 6
// RULE10 - pulse due breaking DAC timing sets timing error bit 5
// RULE11 - pulse due without full preload sets data error bit 4
// RULE12 - any output error aborts run and halts unit until disabled; the code also returns it to idle on a write of control reset bit 1
// RULE13 - output errors clear when output unit is disabled
// RULE14 - normal mode: active bit 2 set on start, cleared at count
// RULE15 - frame mode: active set per good trigger, cleared at count
// RULE16 - preloaded bit 1 sets when all DACs hold four channels
// RULE17 - preloaded clears on each conversion pulse or manual clear
// RULE18 - output idle bit 0 shows while output unit rests idle
// RULE19 - disabling the output unit resets its internal state
// RULE20 - count of zero means continuous, active never cleared by count
// RULE21 - control bit 2 selects normal (0) or frame (1) mode
// RULE22 - DMA idle, busy, error come from one engine state
// RULE23 - status zero after reset, reserved bits read zero
package dss_pkg;
    // ==============================================================
    // register map
    localparam logic [11:0] OFF_CTRL   = 12'h2E8;
    localparam logic [11:0] OFF_STAT   = 12'h2EC;
    localparam logic [11:0] OFF_NCONV  = 12'h2F4;
    localparam logic [11:0] OFF_DMACTL = 12'h304;
    localparam logic [11:0] OFF_DMALEN = 12'h30C;
    // ==============================================================
    // field positions
    localparam int B_OU_ENA   = 0;
    localparam int B_OU_RST   = 1;
    localparam int B_OU_MODE  = 2;
    localparam int B_OU_START = 3;
    localparam int B_CLR_PRLD = 4;
    localparam int B_DMA_ENA  = 0;
    localparam int B_DRAINED  = 20;
    localparam int B_DMA_ERR  = 18;
    localparam int B_DMA_BSY  = 17;
    localparam int B_DMA_IDLE = 16;
    localparam int B_FRM_ERR  = 6;
    localparam int B_TIM_ERR  = 5;
    localparam int B_DAT_ERR  = 4;
    localparam int B_ACT      = 2;
    localparam int B_PRLD     = 1;
    localparam int B_OU_IDLE  = 0;
    localparam int NCONV_W    = 28;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ==============================================================
    // engine states
    typedef enum logic [1:0] {
        DMA_OFF = 2'b00, DMA_IDLE = 2'b01, DMA_BUSY = 2'b10, DMA_FAULT = 2'b11
    } dss_dma_e;
    typedef enum logic [1:0] {
        OU_OFF = 2'b00, OU_IDLE = 2'b01, OU_RUN = 2'b10, OU_HALT = 2'b11
    } dss_ou_e;
endpackage : dss_pkg

// >>> core/dss_status.sv
// Purpose: sequencer DMA and output unit state with status register
// Assumes: event inputs synchronous to clk, one-cycle pulses
// Notes:   reads return data in the cycle after the read strobe
`timescale 1ns/100ps
module dss_status
    import dss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        dma_fetch_last,
    input  wire logic        dma_master_abort,
    input  wire logic        dma_target_abort,
    input  wire logic        frame_trigger,
    input  wire logic        conv_tick,
    input  wire logic        dac_timing_ok,
    input  wire logic        preload_done,
    output logic             dma_fetch_en,
    output logic      [31:0] dma_buf_len,
    output logic             dac_convert,
    output logic             preload_restart
);
    // ==============================================================
    // register bus
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    logic               output_unit_enable;
    logic               normal_or_frame_select;
    logic               dma_enable;
    logic [NCONV_W-1:0] conversions_per_run;
    logic               next_ou_en;
    logic               next_mode;
    logic               next_dma_en;
    logic [NCONV_W-1:0] next_nconv;
    logic [31:0]        next_len;
    logic               len_wr;
    logic               ou_rst_wr;
    logic               start_wr;
    logic               preload_status_clear;
    dss_dma_e           dma_state;

    // self-clearing control bits act only as strobes
    assign len_wr               = wr & hit(addr, OFF_DMALEN);
    assign ou_rst_wr            = wr & hit(addr, OFF_CTRL) & wdata[B_OU_RST];
    assign start_wr             = wr & hit(addr, OFF_CTRL) & wdata[B_OU_START];
    assign preload_status_clear = wr & hit(addr, OFF_CTRL) & wdata[B_CLR_PRLD];

    // writable fields
    always_comb begin
        next_ou_en = output_unit_enable;
        next_mode  = normal_or_frame_select;
        next_dma_en = dma_enable;
        next_nconv = conversions_per_run;
        next_len   = dma_buf_len;
        if (wr && hit(addr, OFF_CTRL)) begin
            next_ou_en = wdata[B_OU_ENA];
            next_mode  = wdata[B_OU_MODE]; // see RULE21
        end
        if (wr && hit(addr, OFF_DMACTL)) begin
            next_dma_en = wdata[B_DMA_ENA];
        end
        if (wr && hit(addr, OFF_NCONV)) begin
            next_nconv = wdata[NCONV_W-1:0];
        end
        // length only latched when a buffer may be validated
        if (len_wr && dma_state == DMA_IDLE) begin
            next_len = wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            output_unit_enable     <= 1'b0;
            normal_or_frame_select <= 1'b0;
            dma_enable             <= 1'b0;
            conversions_per_run    <= '0;
            dma_buf_len            <= RST_WORD;
        end else begin
            output_unit_enable     <= next_ou_en;
            normal_or_frame_select <= next_mode;
            dma_enable             <= next_dma_en;
            conversions_per_run    <= next_nconv;
            dma_buf_len            <= next_len;
        end
    end

    // ==============================================================
    // dma engine
    dss_dma_e next_dma_state;
    logic     dma_buffer_drained;
    logic     next_drained;
    logic     dma_rest_state;
    logic     dma_active_state;
    logic     dma_fault_state;
    logic     abort;

    assign abort = dma_master_abort | dma_target_abort;

    // disable overrides everything, so a fault cannot outlive it
    always_comb begin
        next_dma_state = dma_state;
        next_drained   = dma_buffer_drained;
        if (!dma_enable) begin
            next_dma_state = DMA_OFF; // see RULE5
        end else begin
            case (dma_state)
                DMA_OFF: begin
                    next_dma_state = DMA_IDLE;
                end
                DMA_IDLE: begin
                    if (len_wr) begin
                        next_dma_state = DMA_BUSY; // see RULE8
                        next_drained   = 1'b0;     // see RULE2
                    end
                end
                DMA_BUSY: begin
                    if (abort) begin
                        next_dma_state = DMA_FAULT; // see RULE3
                    end else if (dma_fetch_last) begin
                        next_dma_state = DMA_IDLE;
                        next_drained   = 1'b1; // see RULE1
                    end
                end
                DMA_FAULT: begin
                    next_dma_state = DMA_FAULT; // see RULE4
                end
                default: begin
                    next_dma_state = DMA_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dma_state          <= DMA_OFF;
            dma_buffer_drained <= 1'b0;
        end else begin
            dma_state          <= next_dma_state;
            dma_buffer_drained <= next_drained;
        end
    end

    // one state drives all three flags
    assign dma_rest_state   = (dma_state == DMA_IDLE);  // see RULE7, RULE22
    assign dma_active_state = (dma_state == DMA_BUSY);  // see RULE6, RULE22
    assign dma_fault_state  = (dma_state == DMA_FAULT); // see RULE22
    assign dma_fetch_en     = dma_active_state;

    // ==============================================================
    // output unit
    dss_ou_e            ou_state;
    dss_ou_e            next_ou_state;
    logic [NCONV_W-1:0] conv_cnt;
    logic [NCONV_W-1:0] next_cnt;
    logic [NCONV_W-1:0] cnt_inc;
    logic               frame_overrun_fault;
    logic               pulse_timing_fault;
    logic               preload_missing_fault;
    logic               next_frm;
    logic               next_tim;
    logic               next_dat;
    logic               dacs_preloaded;
    logic               next_prld;
    logic               next_convert;
    logic               conversion_run_active;
    logic               output_unit_rest;
    logic               cont;

    assign cnt_inc = conv_cnt + 1'b1;
    assign cont    = (conversions_per_run == '0);

    // errors take priority over a pulse; frame error beats a tick
    always_comb begin
        next_ou_state = ou_state;
        next_cnt      = conv_cnt;
        next_frm      = frame_overrun_fault;
        next_tim      = pulse_timing_fault;
        next_dat      = preload_missing_fault;
        next_convert  = 1'b0;
        if (!output_unit_enable || ou_rst_wr) begin
            // see RULE13, RULE19
            next_ou_state = output_unit_enable ? OU_IDLE : OU_OFF;
            next_cnt      = '0;
            next_frm      = 1'b0;
            next_tim      = 1'b0;
            next_dat      = 1'b0;
        end else begin
            case (ou_state)
                OU_OFF: begin
                    next_ou_state = OU_IDLE;
                end
                OU_IDLE: begin
                    if (!normal_or_frame_select && start_wr) begin
                        next_ou_state = OU_RUN; // see RULE14
                        next_cnt      = '0;
                    end else if (normal_or_frame_select && frame_trigger) begin
                        next_ou_state = OU_RUN; // see RULE15
                        next_cnt      = '0;
                    end
                end
                OU_RUN: begin
                    if (normal_or_frame_select && frame_trigger && !cont) begin
                        next_frm      = 1'b1;    // see RULE9
                        next_ou_state = OU_HALT; // see RULE12
                    end else if (conv_tick && !dac_timing_ok) begin
                        next_tim      = 1'b1;    // see RULE10
                        next_ou_state = OU_HALT; // see RULE12
                    end else if (conv_tick && !dacs_preloaded) begin
                        next_dat      = 1'b1;    // see RULE11
                        next_ou_state = OU_HALT; // see RULE12
                    end else if (conv_tick) begin
                        next_convert = 1'b1;
                        next_cnt     = cnt_inc;
                        if (!cont && cnt_inc == conversions_per_run) begin
                            // see RULE14, RULE15, RULE20
                            next_ou_state = OU_IDLE;
                        end
                    end
                end
                OU_HALT: begin
                    next_ou_state = OU_HALT; // see RULE12
                end
                default: begin
                    next_ou_state = OU_OFF;
                end
            endcase
        end
    end

    // preload flag: a new preload in the same cycle as a clear wins while the unit is enabled
    always_comb begin
        next_prld = dacs_preloaded;
        if (next_convert || preload_status_clear || !output_unit_enable
            || ou_rst_wr) begin
            next_prld = 1'b0; // see RULE17
        end
        if (preload_done && output_unit_enable) begin
            next_prld = 1'b1; // see RULE16
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ou_state              <= OU_OFF;
            conv_cnt              <= '0;
            frame_overrun_fault   <= 1'b0;
            pulse_timing_fault    <= 1'b0;
            preload_missing_fault <= 1'b0;
            dacs_preloaded        <= 1'b0;
            dac_convert           <= 1'b0;
            preload_restart       <= 1'b0;
        end else begin
            ou_state              <= next_ou_state;
            conv_cnt              <= next_cnt;
            frame_overrun_fault   <= next_frm;
            pulse_timing_fault    <= next_tim;
            preload_missing_fault <= next_dat;
            dacs_preloaded        <= next_prld;
            dac_convert           <= next_convert;
            preload_restart       <= preload_status_clear;
        end
    end

    assign conversion_run_active = (ou_state == OU_RUN);  // see RULE14
    assign output_unit_rest      = (ou_state == OU_IDLE); // see RULE18

    // ==============================================================
    // read path, one cycle latency
    logic [31:0] stat_word;
    logic [31:0] next_rdata;

    // reserved positions stay zero
    always_comb begin
        stat_word             = RST_WORD; // see RULE23
        stat_word[B_DRAINED]  = dma_buffer_drained;
        stat_word[B_DMA_ERR]  = dma_fault_state;
        stat_word[B_DMA_BSY]  = dma_active_state;
        stat_word[B_DMA_IDLE] = dma_rest_state;
        stat_word[B_FRM_ERR]  = frame_overrun_fault;
        stat_word[B_TIM_ERR]  = pulse_timing_fault;
        stat_word[B_DAT_ERR]  = preload_missing_fault;
        stat_word[B_ACT]      = conversion_run_active;
        stat_word[B_PRLD]     = dacs_preloaded;
        stat_word[B_OU_IDLE]  = output_unit_rest;
    end

    // unmapped addresses read zero; data holds only one cycle
    always_comb begin
        next_rdata = RST_WORD;
        if (rd) begin
            if (hit(addr, OFF_STAT)) begin
                next_rdata = stat_word;
            end else if (hit(addr, OFF_CTRL)) begin
                next_rdata[B_OU_ENA]  = output_unit_enable;
                next_rdata[B_OU_MODE] = normal_or_frame_select;
            end else if (hit(addr, OFF_NCONV)) begin
                next_rdata[NCONV_W-1:0] = conversions_per_run;
            end else if (hit(addr, OFF_DMACTL)) begin
                next_rdata[B_DMA_ENA] = dma_enable;
            end else if (hit(addr, OFF_DMALEN)) begin
                next_rdata = dma_buf_len;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= RST_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==============================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_drain_set;
        dma_enable && dma_active_state && dma_fetch_last && !abort
        |=> dma_buffer_drained && dma_rest_state;
    endproperty
    a_drain_set: assert property (p_drain_set) // see RULE1
        else $error("drained flag not set after last fetch");

    property p_drain_clr;
        dma_enable && dma_rest_state && len_wr
        |=> !dma_buffer_drained && dma_fetch_en;
    endproperty
    a_drain_clr: assert property (p_drain_clr) // see RULE2
        else $error("drained flag not cleared on new buffer");

    property p_dma_err;
        dma_enable && dma_active_state && abort |=> dma_fault_state;
    endproperty
    a_dma_err: assert property (p_dma_err) // see RULE3
        else $error("abort did not raise dma error");

    property p_err_hold;
        dma_fault_state && dma_enable |=> dma_fault_state && !dma_fetch_en;
    endproperty
    a_err_hold: assert property (p_err_hold) // see RULE4
        else $error("dma engine left error while enabled");

    property p_err_clr;
        dma_fault_state && !dma_enable |=> !dma_fault_state;
    endproperty
    a_err_clr: assert property (p_err_clr) // see RULE5
        else $error("dma error survived disable");

    property p_one_flag;
        $past(dma_enable) && dma_enable
        |-> $onehot({dma_rest_state, dma_active_state, dma_fault_state});
    endproperty
    a_one_flag: assert property (p_one_flag) // see RULE22
        else $error("dma flags not one-hot");

    property p_frm_err;
        output_unit_enable && !ou_rst_wr && conversion_run_active
        && normal_or_frame_select && frame_trigger && !cont
        |=> frame_overrun_fault && !conversion_run_active;
    endproperty
    a_frm_err: assert property (p_frm_err) // see RULE9
        else $error("early trigger missed frame error");

    property p_tim_err;
        output_unit_enable && !ou_rst_wr && conversion_run_active
        && conv_tick && !dac_timing_ok && !(normal_or_frame_select
        && frame_trigger)
        |=> pulse_timing_fault && !dac_convert;
    endproperty
    a_tim_err: assert property (p_tim_err) // see RULE10
        else $error("timing violation not flagged");

    property p_dat_err;
        output_unit_enable && !ou_rst_wr && conversion_run_active
        && conv_tick && dac_timing_ok && !dacs_preloaded
        && !(normal_or_frame_select && frame_trigger)
        |=> preload_missing_fault && !dac_convert;
    endproperty
    a_dat_err: assert property (p_dat_err) // see RULE11
        else $error("missing preload not flagged");

    property p_halt;
        (frame_overrun_fault || pulse_timing_fault || preload_missing_fault)
        && output_unit_enable && !ou_rst_wr
        |=> !conversion_run_active && !dac_convert && !output_unit_rest;
    endproperty
    a_halt: assert property (p_halt) // see RULE12
        else $error("output unit not halted on error");

    property p_ou_clr;
        !output_unit_enable |=> !frame_overrun_fault && !pulse_timing_fault
            && !preload_missing_fault && !conversion_run_active;
    endproperty
    a_ou_clr: assert property (p_ou_clr) // see RULE13
        else $error("output errors survived disable");

    property p_prld_clr;
        dac_convert && !$past(preload_done) |-> !dacs_preloaded;
    endproperty
    a_prld_clr: assert property (p_prld_clr) // see RULE17
        else $error("preload flag kept through pulse");

    property p_cont;
        output_unit_enable && !ou_rst_wr && conversion_run_active && cont
        && conv_tick && dac_timing_ok && dacs_preloaded && !frame_trigger
        |=> conversion_run_active && dac_convert;
    endproperty
    a_cont: assert property (p_cont) // see RULE20
        else $error("continuous run stopped");

    c_drain: cover property (dma_active_state ##1 dma_buffer_drained);
    c_run_done: cover property (conversion_run_active ##1 output_unit_rest);
    c_frm: cover property (frame_overrun_fault);
    c_dat: cover property (preload_missing_fault);
endmodule : dss_status

// >>> tb/dss_far_model.sv
// Purpose: far side of the status block, DMA fetcher and DAC preload path
// Assumes: one clock, every event a one-cycle pulse
// Notes:   aborts only on bench request; starve stands for an empty FIFO
`timescale 1ns/100ps
module dss_far_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       dma_fetch_en,
    input  wire logic       dac_convert,
    input  wire logic       preload_restart,
    input  wire logic       starve,
    input  wire logic [1:0] abort_sel,
    output logic            dma_fetch_last,
    output logic            dma_master_abort,
    output logic            dma_target_abort,
    output logic            preload_done
);
    logic [3:0] fcnt;
    logic [2:0] pcnt;
    logic       loaded;
    // DMA events only while the engine is busy, so a stray pulse can not hide
    assign dma_fetch_last   = dma_fetch_en && fcnt == 4'hC && abort_sel == 2'h0;
    assign dma_master_abort = dma_fetch_en && fcnt == 4'h3 && abort_sel[0];
    assign dma_target_abort = dma_fetch_en && fcnt == 4'h3 && abort_sel[1];
    assign preload_done     = !loaded && !starve && pcnt == 3'h3;
    // reload takes a few cycles, so a cleared flag can be seen before refill
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fcnt   <= 4'h0;
            pcnt   <= 3'h0;
            loaded <= 1'b0;
        end else begin
            fcnt   <= dma_fetch_en ? fcnt + 4'h1 : 4'h0;
            pcnt   <= (loaded || starve) ? 3'h0 : pcnt + 3'h1;
            loaded <= preload_done | (loaded & ~(dac_convert | preload_restart | starve));
        end
    end
endmodule : dss_far_model

// >>> tb/test_dac_sequencer_status.sv
// Purpose: self-checking bench of the sequencer status block
// Assumes: 100 MHz clk, reset held 16 cycles
// Notes:   status reads are masked where a flag races the far side
`timescale 1ns/100ps
module test_dac_sequencer_status;
    import dss_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, dma_buf_len, len, rv;
    logic        dma_fetch_last, dma_master_abort, dma_target_abort, dma_fetch_en;
    logic        frame_trigger = 1'b0, conv_tick = 1'b0, dac_timing_ok = 1'b1;
    logic        preload_done, dac_convert, preload_restart, starve = 1'b1;
    logic [1:0]  abort_sel = 2'h0;
    int          fail_count = 0, checked = 0, seed = 2, n, i;
    always #5 clk = ~clk;
    dss_status dss_status_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .dma_fetch_last,
        .dma_master_abort, .dma_target_abort, .frame_trigger, .conv_tick, .dac_timing_ok,
        .preload_done, .dma_fetch_en, .dma_buf_len, .dac_convert, .preload_restart);
    dss_far_model dss_far_model_i (.clk, .nrst, .dma_fetch_en, .dac_convert, .preload_restart,
        .starve, .abort_sel, .dma_fetch_last, .dma_master_abort, .dma_target_abort,
        .preload_done);
    // ==============================================================
    // bus tasks and checks
    function automatic logic [31:0] b(input int p);
        return 32'h1 << p;
    endfunction : b
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // read data stands one cycle only, so it is taken just after the edge
    task automatic rreg(input logic [11:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask : rreg
    task automatic stat(input logic [31:0] exp, input logic [31:0] msk);
        rreg(OFF_STAT);
        chk("status", exp & msk, rv & msk);
    endtask : stat
    task automatic wait_bit(input int p);
        for (int k = 0; k < 60; k++) begin
            rreg(OFF_STAT);
            if (rv[p] === 1'b1) return;
        end
        fail_count++;
        $display("BAD status bit %0d expected 1 seen 0", p);
        report_and_stop();
    endtask : wait_bit
    task automatic tick(input logic ok, input logic exp);
        @(posedge clk);
        conv_tick <= 1'b1;
        dac_timing_ok <= ok;
        @(posedge clk);
        conv_tick <= 1'b0;
        dac_timing_ok <= 1'b1;
        #1 chk("dac_convert", {31'h0, exp}, {31'h0, dac_convert});
    endtask : tick
    task automatic trig;
        @(posedge clk);
        frame_trigger <= 1'b1;
        @(posedge clk);
        frame_trigger <= 1'b0;
    endtask : trig
    // ==============================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        stat(32'h0, ALL);
        wreg(OFF_STAT, ALL);
        rreg(12'h2F0);
        chk("unmapped", 32'h0, rv);
        stat(32'h0, ALL);
        // dma buffer, restart, then both abort kinds
        wreg(OFF_DMACTL, 32'h1);
        stat(b(B_DMA_IDLE), ALL);
        len = $random(seed);
        wreg(OFF_DMALEN, len);
        stat(b(B_DMA_BSY), ALL);
        chk("dma_buf_len", len, dma_buf_len);
        wait_bit(B_DRAINED);
        stat(b(B_DRAINED) | b(B_DMA_IDLE), ALL);
        wreg(OFF_DMALEN, ~len);
        stat(b(B_DMA_BSY), ALL);
        wait_bit(B_DMA_IDLE);
        for (i = 0; i < 2; i++) begin
            abort_sel <= 2'h1 << i;
            wreg(OFF_DMALEN, len);
            wait_bit(B_DMA_ERR);
            wreg(OFF_DMALEN, ~len);
            stat(b(B_DMA_ERR), ALL);
            chk("dma_buf_len", len, dma_buf_len);
            chk("dma_fetch_en", 32'h0, {31'h0, dma_fetch_en});
            wreg(OFF_DMACTL, 32'h0);
            stat(32'h0, ALL);
            wreg(OFF_DMACTL, 32'h1);
            wait_bit(B_DMA_IDLE);
        end
        // output unit: normal run of a random count, then continuous
        starve <= 1'b0;
        n = 1 + ({$random(seed)} % 4);
        wreg(OFF_NCONV, n);
        wreg(OFF_CTRL, 32'h11); // clear resyncs the far side preload
        wait_bit(B_PRLD);
        stat(b(B_PRLD) | b(B_OU_IDLE), 32'hFF);
        wreg(OFF_CTRL, 32'h11);
        #1 chk("preload_restart", 32'h1, {31'h0, preload_restart});
        stat(b(B_OU_IDLE), 32'hFF);
        wait_bit(B_PRLD);
        wreg(OFF_CTRL, 32'h9);
        stat(b(B_ACT) | b(B_PRLD), 32'hFF);
        for (i = 0; i < n; i++) begin
            tick(1'b1, 1'b1);
            wait_bit(B_PRLD);
        end
        stat(b(B_OU_IDLE) | b(B_PRLD), 32'hFF);
        wreg(OFF_NCONV, 32'h0);
        wreg(OFF_CTRL, 32'h9);
        for (i = 0; i < 3; i++) begin
            tick(1'b1, 1'b1);
            wait_bit(B_PRLD);
        end
        stat(b(B_ACT) | b(B_PRLD), 32'hFF);
        // underrun: one last good pulse, then a pulse with no preload
        starve <= 1'b1;
        tick(1'b1, 1'b1);
        tick(1'b1, 1'b0);
        stat(b(B_DAT_ERR), 32'hFF);
        wreg(OFF_CTRL, 32'h3);
        stat(b(B_OU_IDLE), 32'hFD);
        wreg(OFF_CTRL, 32'h0);
        stat(32'h0, 32'hFF);
        // pulse that breaks the DAC timing
        starve <= 1'b0;
        wreg(OFF_CTRL, 32'h11);
        wait_bit(B_PRLD);
        wreg(OFF_CTRL, 32'h9);
        tick(1'b0, 1'b0);
        stat(b(B_TIM_ERR), 32'hFD);
        wreg(OFF_CTRL, 32'h0);
        stat(32'h0, 32'hFF);
        // frame mode: one full frame, then a third trigger before the count is done
        wreg(OFF_NCONV, 32'h3);
        wreg(OFF_CTRL, 32'h15);
        wait_bit(B_PRLD);
        trig();
        for (i = 0; i < 3; i++) begin
            tick(1'b1, 1'b1);
            wait_bit(B_PRLD);
        end
        stat(b(B_OU_IDLE) | b(B_PRLD), 32'hFF);
        trig();
        stat(b(B_ACT), 32'hFD);
        tick(1'b1, 1'b1);
        trig();
        stat(b(B_FRM_ERR), 32'hFD);
        wreg(OFF_CTRL, 32'h0);
        stat(32'h0, 32'hFF);
        report_and_stop();
    end
endmodule : test_dac_sequencer_status
